// *** rtl/fault_log_pkg.sv ***
// constants and carrier types for the fault log record framer
package fault_log_pkg;
    localparam int          REC_LEN        = 147;
    localparam logic [7:0]  REC_LEN_BYTE   = 8'h93;
    localparam logic [7:0]  OFS_VIN_PEAK   = 8'h13;
    localparam logic [7:0]  OFS_TEMP_CH0   = 8'h15;
    localparam logic [7:0]  OFS_TEMP_CH1   = 8'h17;
    localparam logic [7:0]  OFS_TEMP_INT   = 8'h19;
    localparam logic [7:0]  OFS_EVENT_N    = 8'h1B;
    localparam logic [7:0]  OFS_EVENT_END  = 8'h25;
    localparam logic [4:0]  MUX_LAST_STEP  = 5'h19;
    localparam logic [2:0]  EVENT_PAGES    = 3'h6;
    localparam logic [15:0] PEAK_RESET     = 16'h0000;

    // one conversion result from the measurement multiplexer
    typedef struct packed {
        logic [4:0]  step;
        logic [2:0]  kind;
        logic [15:0] value;
    } conv_s;

    // conversion kinds that land in the record
    localparam logic [2:0] K_VOUT0 = 3'h0;
    localparam logic [2:0] K_VOUT1 = 3'h1;
    localparam logic [2:0] K_IOUT0 = 3'h2;
    localparam logic [2:0] K_IOUT1 = 3'h3;
    localparam logic [2:0] K_VIN   = 3'h4;
    localparam logic [2:0] K_IIN   = 3'h5;
    localparam logic [2:0] K_TEMP0 = 3'h6;
    localparam logic [2:0] K_TEMP1 = 3'h7;
    localparam logic [4:0] STEP_TEMP_INT = 5'h18;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } rec_byte_s;

    typedef enum logic [1:0] {ST_IDLE, ST_DRAIN, ST_STORE} cap_state_e;
endpackage

// *** rtl/fault_log_framer.sv ***
// fault record capture and byte framer for bytes 19 to 38
module fault_log_framer (
    input  wire logic                   i_clock,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_conv_valid,
    input  wire fault_log_pkg::conv_s   i_conv,
    input  wire logic                   i_fault,
    input  wire logic                   i_peak_clear_command,
    input  wire logic                   i_fault_log_read_command,
    input  wire logic                   i_store_done,
    output logic                        o_store_start,
    output logic [2:0]                  o_store_pages,
    output logic                        o_log_valid,
    output logic                        o_busy,
    output logic                        o_byte_valid,
    input  wire logic                   i_byte_ready,
    output fault_log_pkg::rec_byte_s    o_byte
);
    import fault_log_pkg::*;

    logic [15:0] input_voltage_peak;
    logic [15:0] temp_ch0, temp_ch1, temp_int;
    logic [15:0] live_page [6];
    logic [15:0] event_page [6];
    logic [15:0] live_t0, live_t1, live_ti;
    cap_state_e  state;
    logic        log_valid;
    logic        reading;
    logic [7:0]  rd_ofs;

    // linear-11 compare: exponent signed 5 bits, mantissa signed 11 bits
    function automatic logic signed [47:0] lin11_val(input logic [15:0] w);
        logic signed [4:0]  e;
        logic signed [10:0] m;
        logic signed [47:0] r;
        e = w[15:11];
        m = w[10:0];
        r = 48'(m) <<< 16;
        if (e[4]) r = r >>> (-e);
        else r = r <<< e;
        return r;
    endfunction

    // byte of a big-endian word: high first
    function automatic logic [7:0] hi_lo(input logic [15:0] w, input logic lo);
        return lo ? w[7:0] : w[15:8];
    endfunction

    wire conv_vin   = i_conv_valid && i_conv.kind == K_VIN;
    wire vin_higher = lin11_val(i_conv.value) > lin11_val(input_voltage_peak);
    wire cycle_end  = i_conv_valid && i_conv.step == MUX_LAST_STEP;

    // peak tracking; clear wins only when no VIN sample arrives together, else that sample loads
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            input_voltage_peak <= PEAK_RESET;
        end else if (conv_vin && (vin_higher || i_peak_clear_command)) begin
            input_voltage_peak <= i_conv.value;
        end else if (i_peak_clear_command) begin
            input_voltage_peak <= PEAK_RESET;
        end
    end

    // live multiplexer pass; linear-16 arrives as mantissa only
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 6; i++) live_page[i] <= 16'h0000;
            live_t0 <= 16'h0000;
            live_t1 <= 16'h0000;
            live_ti <= 16'h0000;
        end else if (i_conv_valid) begin
            if (i_conv.step == STEP_TEMP_INT) live_ti <= i_conv.value;
            else if (i_conv.kind == K_TEMP0) live_t0 <= i_conv.value;
            else if (i_conv.kind == K_TEMP1) live_t1 <= i_conv.value;
            else live_page[i_conv.kind] <= i_conv.value;
        end
    end

    // fault: finish the pass through the last step, then freeze and store
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            log_valid <= 1'b0;
            temp_ch0 <= 16'h0000;
            temp_ch1 <= 16'h0000;
            temp_int <= 16'h0000;
            for (int i = 0; i < 6; i++) event_page[i] <= 16'h0000;
        end else begin
            unique case (state)
                ST_IDLE: if (i_fault) state <= ST_DRAIN;
                ST_DRAIN: if (cycle_end) begin
                    state <= ST_STORE;
                    event_page <= live_page;
                    temp_ch0 <= live_t0;
                    temp_ch1 <= live_t1;
                    temp_int <= live_ti;
                end
                ST_STORE: if (i_store_done) begin
                    state <= ST_IDLE;
                    log_valid <= 1'b1;
                end
            endcase
        end
    end

    // nonvolatile store of header plus all event pages, one pulse
    assign o_store_start = state == ST_DRAIN && cycle_end;
    assign o_store_pages = EVENT_PAGES;
    assign o_log_valid   = log_valid;
    assign o_busy        = state != ST_IDLE;

    // record byte selection for this slice of the record
    wire       lo_half  = rd_ofs[0] ^ OFS_VIN_PEAK[0];
    wire [7:0] pg_idx   = (rd_ofs - OFS_EVENT_N) >> 1;
    wire        in_peak  = rd_ofs < OFS_TEMP_CH0;
    wire        in_t0    = rd_ofs < OFS_TEMP_CH1;
    wire        in_t1    = rd_ofs < OFS_TEMP_INT;
    wire        in_ti    = rd_ofs < OFS_EVENT_N;
    wire [15:0] sel_word = in_peak ? input_voltage_peak
                         : in_t0   ? temp_ch0
                         : in_t1   ? temp_ch1
                         : in_ti   ? temp_int
                         : event_page[pg_idx[2:0]];
    wire [7:0]  sel_byte = hi_lo(sel_word, lo_half);

    // two-entry skid buffer so a stalled reader loses no byte
    rec_byte_s buf_q [2];
    logic [1:0] buf_cnt;
    wire push = reading && buf_cnt != 2'h2;
    wire pop  = o_byte_valid && i_byte_ready;
    wire last_byte = rd_ofs == OFS_EVENT_END + 8'h01;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            reading <= 1'b0;
            rd_ofs <= OFS_VIN_PEAK;
        end else if (!reading && i_fault_log_read_command && log_valid) begin
            reading <= 1'b1;
            rd_ofs <= OFS_VIN_PEAK;
        end else if (push) begin
            reading <= !last_byte;
            rd_ofs <= rd_ofs + 8'h01;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            buf_cnt <= 2'h0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            if (pop) buf_q[0] <= buf_q[1];
            if (push) buf_q[(pop ? buf_cnt - 2'h1 : buf_cnt) == 2'h0 ? 0 : 1]
                <= '{data: sel_byte, last: last_byte};
            buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    assign o_byte_valid = buf_cnt != 2'h0;
    assign o_byte       = buf_q[0];
endmodule

// *** tb/fault_log_framer_properties.sv ***
// port assertions for the fault log framer
module fault_log_framer_properties
    import fault_log_pkg::*;
(
    input wire logic       i_clock,
    input wire logic       i_sys_rst,
    input wire logic       i_conv_valid,
    input wire conv_s      i_conv,
    input wire logic       i_fault_log_read_command,
    input wire logic       i_store_done,
    input wire logic       o_store_start,
    input wire logic [2:0] o_store_pages,
    input wire logic       o_log_valid,
    input wire logic       o_byte_valid,
    input wire logic       i_byte_ready,
    input wire rec_byte_s  o_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    property p_pages; o_store_pages == EVENT_PAGES; endproperty
    a_pages: assert property (p_pages) else $error("page count");
    property p_start;
        o_store_start |-> i_conv_valid && i_conv.step == MUX_LAST_STEP;
    endproperty
    a_start: assert property (p_start) else $error("early store");
    property p_logv; $rose(o_log_valid) |-> $past(i_store_done); endproperty
    a_logv: assert property (p_logv) else $error("log early");
    property p_keep; o_log_valid |=> o_log_valid; endproperty
    a_keep: assert property (p_keep) else $error("log lost");
    property p_hold;
        o_byte_valid && !i_byte_ready |=> o_byte_valid && $stable(o_byte);
    endproperty
    a_hold: assert property (p_hold) else $error("byte moved");
    property p_none;
        i_fault_log_read_command && !o_log_valid && !o_byte_valid
            |-> ##1 !o_byte_valid [*2];
    endproperty
    a_none: assert property (p_none) else $error("empty read");
    property p_go;
        i_fault_log_read_command && o_log_valid && !o_byte_valid
            |-> ##2 o_byte_valid && !o_byte.last;
    endproperty
    a_go: assert property (p_go) else $error("no answer");
    property p_end;
        o_byte_valid && o_byte.last && i_byte_ready |=> !o_byte_valid;
    endproperty
    a_end: assert property (p_end) else $error("byte past end");
endmodule

// *** tb/fault_log_host.sv ***
// memory writer and record reader at the framer's far side
module fault_log_host (
    input  wire logic i_clock,
    input  wire logic i_stall,
    input  wire logic i_store_start,
    output logic      o_store_done,
    output logic      o_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] cnt = 3'h0;
    assign o_ready = !i_stall;
    initial o_store_done = 1'b0;
    // a slow writer, so the framer must stay busy meanwhile
    always @(posedge i_clock) begin
        if (i_store_start) cnt = 3'h4;
        else if (cnt != 3'h0) cnt = cnt - 3'h1;
        #5 o_store_done = (cnt == 3'h1);
    end
endmodule

// *** tb/tb.sv ***
// bench for the fault log framer: refusal, captures, peak clear, stalls
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import fault_log_pkg::*;
    logic i_clock, i_sys_rst, i_conv_valid, i_fault, i_peak_clear_command;
    logic i_fault_log_read_command, stall, ready, done, o_store_start;
    logic o_log_valid, o_busy, o_byte_valid;
    logic [2:0] o_store_pages;
    conv_s i_conv;
    rec_byte_s o_byte;
    logic [8:0] q[$];
    logic [15:0] v[9], pk;
    logic [31:0] rs = 32'h207F, sr = 32'h207F;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    fault_log_framer fault_log_framer_inst (.i_clock, .i_sys_rst,
        .i_conv_valid, .i_conv, .i_fault, .i_peak_clear_command,
        .i_fault_log_read_command, .i_store_done(done), .o_store_start,
        .o_store_pages, .o_log_valid, .o_busy, .o_byte_valid,
        .i_byte_ready(ready), .o_byte);
    fault_log_host fault_log_host_inst (.i_clock, .i_stall(stall),
        .i_store_start(o_store_start), .o_store_done(done), .o_ready(ready));
    // numeric value of a linear-11 word, so the peak model follows the format
    function real lv(input logic [15:0] w);
        return $itor($signed(w[10:0])) * (2.0 ** $signed(w[15:11]));
    endfunction
    function logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task tick;
        @(posedge i_clock);
        #5;
    endtask
    task conv(input logic [4:0] s, input logic [2:0] k, input logic [15:0] x);
        i_conv = '{s, k, x};
        i_conv_valid = 1;
        tick;
        i_conv_valid = 0;
        tick;
    endtask
    // one mux pass, fault raised mid-pass at step 15
    task ev;
        for (int s = 0; s < 26; s++) begin
            rs = nxt(rs);
            if (s < 9) v[s] = rs[15:0];
            if (s < 8) conv(s[4:0], s[2:0], v[s]);
            if (s == 4 && lv(v[4]) > lv(pk)) pk = v[4];
            if (s == 15) begin
                i_fault = 1;
                tick;
                i_fault = 0;
            end
            if (s == 24) conv(STEP_TEMP_INT, K_TEMP0, v[8]);
            if (s == 25) conv(MUX_LAST_STEP, K_VOUT0, v[0]);
        end
        for (int i = 0; i < 50 && o_busy !== 1'b0; i++) tick;
    endtask
    task rd;
        logic [15:0] w[10];
        w = '{pk, v[6], v[7], v[8], v[0], v[1], v[2], v[3], v[4], v[5]};
        foreach (w[i]) begin
            q.push_back({w[i][15:8], 1'b0});
            q.push_back({w[i][7:0], i == 9});
        end
        i_fault_log_read_command = 1;
        tick;
        i_fault_log_read_command = 0;
        for (int i = 0; i < 300 && q.size() != 0; i++) tick;
        chk("left", 9'h0, 9'(q.size()));
        $display("test done");
    endtask
    initial begin
        i_clock = 0;
        forever #25 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop;
        end
        if (o_byte_valid && ready) begin
            chk("byte", q.size() ? q.pop_front() : 'x, o_byte);
        end
        #5 sr = nxt(sr);
        stall = sr[0] & sr[5];
    end
    initial begin
        {i_conv_valid, i_fault, i_peak_clear_command, stall} = 0;
        i_fault_log_read_command = 0;
        i_conv = '0;
        pk = 0;
        i_sys_rst = 1;
        repeat (16) @(posedge i_clock);
        #5 i_sys_rst = 0;
        tick;
        i_fault_log_read_command = 1;
        tick;
        i_fault_log_read_command = 0;
        repeat (8) tick;
        chk("log_valid", 9'h0, {8'h0, o_log_valid});
        $display("test done");
        ev;
        ev;
        rd;
        i_peak_clear_command = 1;
        tick;
        i_peak_clear_command = 0;
        pk = 0;
        ev;
        rd;
        report_and_stop;
    end
endmodule
bind fault_log_framer fault_log_framer_properties fault_log_framer_properties_inst (
    .i_clock, .i_sys_rst, .i_conv_valid, .i_conv, .i_fault_log_read_command,
    .i_store_done, .o_store_start, .o_store_pages, .o_log_valid,
    .o_byte_valid, .i_byte_ready, .o_byte);
